/* File: logic/dcs_pkg.sv */
// Constants, types and helpers shared by the cycle sequencer files
package dcs_pkg;

	localparam int NCH    = 4;
	localparam int CH_W   = 2;
	localparam int ADDR_W = 8;
	localparam int DSC_W  = 18;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_PRIO     = 8'h04;
	localparam logic [7:0] OFS_SWREQ    = 8'h08;
	localparam logic [7:0] OFS_ALT      = 8'h0c;
	localparam logic [7:0] OFS_STAT     = 8'h10;
	localparam logic [7:0] OFS_DESC     = 8'h20;
	localparam logic [7:0] OFS_DESC_END = 8'h3c;

	// Descriptor field positions, same layout as the in-memory control word
	localparam int DSC_TYP_LSB = 0;
	localparam int DSC_N_LSB   = 4;
	localparam int DSC_RP_LSB  = 14;

	// Status field positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_CH   = 1;
	localparam int STAT_PEND = 4;
	localparam int STAT_AUTO = 8;
	localparam int STAT_TYP  = 12;

	// Reset values and batch limits
	localparam logic [3:0]       CH_RST    = 4'h0;
	localparam logic [DSC_W-1:0] DSC_RST   = 18'h0;
	localparam logic [3:0]       RP_MAX    = 4'ha;
	localparam logic [10:0]      BATCH_MAX = 11'h400;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		CYC_INVALID = 3'b000,
		CYC_BASIC   = 3'b001,
		CYC_AUTO    = 3'b010,
		CYC_PING    = 3'b011,
		CYC_MSG_PRI = 3'b100,
		CYC_MSG_ALT = 3'b101,
		CYC_PSG_PRI = 3'b110,
		CYC_PSG_ALT = 3'b111
	} dcs_cyc_t;

	typedef enum logic [1:0] {
		ST_ARB   = 2'b00,
		ST_FETCH = 2'b01,
		ST_XFER  = 2'b10,
		ST_WB    = 2'b11
	} dcs_state_t;

	// Aligned and inside the map
	function automatic logic addr_ok(input logic [7:0] a);
		return (a[1:0] == 2'b00) && ((a <= OFS_STAT) || ((a >= OFS_DESC) && (a <= OFS_DESC_END)));
	endfunction

	// Transfers per batch from the exponent, saturating at 1024 from code ten up
	function automatic logic [10:0] batch_size(input logic [3:0] rp);
		if (rp >= RP_MAX) begin
			return BATCH_MAX;
		end
		return 11'h001 << rp;
	endfunction

	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

endpackage

/* File: logic/dcs_if.sv */
// Carriers between the sequencer, its bus front end and its arbiter
`timescale 1ns/10ps
interface dcs_reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input rd_data);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output rd_data);
endinterface

interface dcs_arb_if;
	logic [dcs_pkg::NCH-1:0]  cand;
	logic [dcs_pkg::NCH-1:0]  high;
	logic                     vld;
	logic [dcs_pkg::CH_W-1:0] ch;
	modport req (output cand, high, input vld, ch);
	modport arb (input cand, high, output vld, ch);
endinterface

/* File: logic/dcs_arbiter.sv */
// Fixed two-level priority pick among requesting channels
`timescale 1ns/10ps
module dcs_arbiter (
	dcs_arb_if.arb aif
);
	import dcs_pkg::*;

	logic [NCH-1:0] pool;

	// High level shadows default level; lowest index wins inside a level
	always_comb begin
		pool    = ((aif.cand & aif.high) != '0) ? (aif.cand & aif.high) : aif.cand;
		aif.vld = 1'b0;
		aif.ch  = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (pool[i]) begin
				aif.vld = 1'b1;
				aif.ch  = CH_W'(i);
			end
		end
	end

endmodule // dcs_arbiter

/* File: logic/dcs_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/10ps
module dcs_axil_slave (
	input  logic        aclk,
	input  logic        aresetn,
	input  logic [7:0]  awaddr,
	input  logic        awvalid,
	output logic        awready,
	input  logic [31:0] wdata,
	input  logic [3:0]  wstrb,
	input  logic        wvalid,
	output logic        wready,
	output logic [1:0]  bresp,
	output logic        bvalid,
	input  logic        bready,
	input  logic [7:0]  araddr,
	input  logic        arvalid,
	output logic        arready,
	output logic [31:0] rdata,
	output logic [1:0]  rresp,
	output logic        rvalid,
	input  logic        rready,
	dcs_reg_if.bus      rif
);
	import dcs_pkg::*;

	logic        aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, awr_r, awr_nxt, wr_r, wr_nxt;
	logic [7:0]  wa_r, wa_nxt, ra_r, ra_nxt;
	logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic [3:0]  ws_r, ws_nxt;
	logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
	logic        rp_r, rp_nxt, rv_r, rv_nxt, arr_r, arr_nxt;

	// Address and data are taken in either order; the write fires once both are held
	always_comb begin
		aw_nxt = aw_r;
		w_nxt  = w_r;
		wa_nxt = wa_r;
		wd_nxt = wd_r;
		ws_nxt = ws_r;
		bv_nxt = bv_r;
		br_nxt = br_r;
		if (awvalid && awr_r) begin
			aw_nxt = 1'b1;
			wa_nxt = awaddr;
		end
		if (wvalid && wr_r) begin
			w_nxt  = 1'b1;
			wd_nxt = wdata;
			ws_nxt = wstrb;
		end
		if (bv_r && bready) begin
			bv_nxt = 1'b0;
		end
		if (rif.wr_en) begin
			aw_nxt = 1'b0;
			w_nxt  = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = addr_ok(wa_r) ? RESP_OKAY : RESP_SLVERR;
		end
		// Ready drops while a response is owed, so one write at most is in flight
		awr_nxt = !aw_nxt && !bv_nxt;
		wr_nxt  = !w_nxt && !bv_nxt;
		rp_nxt  = rp_r;
		ra_nxt  = ra_r;
		rv_nxt  = rv_r;
		rd_nxt  = rd_r;
		rr_nxt  = rr_r;
		if (arvalid && arr_r) begin
			rp_nxt = 1'b1;
			ra_nxt = araddr;
		end
		if (rv_r && rready) begin
			rv_nxt = 1'b0;
		end
		if (rp_r) begin
			rp_nxt = 1'b0;
			rv_nxt = 1'b1;
			rd_nxt = addr_ok(ra_r) ? rif.rd_data : 32'h0;
			rr_nxt = addr_ok(ra_r) ? RESP_OKAY : RESP_SLVERR;
		end
		arr_nxt = !rp_nxt && !rv_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{aw_r, w_r, bv_r, rp_r, rv_r} <= 5'h00;
			{awr_r, wr_r, arr_r}          <= 3'h0;
			wa_r <= 8'h00;
			ra_r <= 8'h00;
			wd_r <= 32'h0;
			rd_r <= 32'h0;
			ws_r <= 4'h0;
			br_r <= RESP_OKAY;
			rr_r <= RESP_OKAY;
		end else begin
			{aw_r, w_r, bv_r, rp_r, rv_r} <= {aw_nxt, w_nxt, bv_nxt, rp_nxt, rv_nxt};
			{awr_r, wr_r, arr_r}          <= {awr_nxt, wr_nxt, arr_nxt};
			wa_r <= wa_nxt;
			ra_r <= ra_nxt;
			wd_r <= wd_nxt;
			rd_r <= rd_nxt;
			ws_r <= ws_nxt;
			br_r <= br_nxt;
			rr_r <= rr_nxt;
		end
	end

	assign rif.wr_en   = aw_r && w_r && !bv_r;
	assign rif.wr_addr = wa_r;
	assign rif.wr_data = wd_r;
	assign rif.wr_strb = addr_ok(wa_r) ? ws_r : 4'h0;
	assign rif.rd_addr = ra_r;
	assign awready     = awr_r;
	assign wready      = wr_r;
	assign bvalid      = bv_r;
	assign bresp       = br_r;
	assign arready     = arr_r;
	assign rvalid      = rv_r;
	assign rdata       = rd_r;
	assign rresp       = rr_r;

endmodule // dcs_axil_slave

/* File: logic/dcs_sequencer.sv */
// Four-channel cycle sequencer: arbitration, batching and cycle completion
// Notes on behaviour
// - Re-arbitrate over all channels after transfers
// - Codes 0..3: invalid, basic, auto, ping-pong
// - Codes 4..7: memory then peripheral scatter-gather
// - Each service is a batch of 2^R
// - No other channel moves during a batch
// - Completed cycle rewrites its type invalid
// - Basic: batch, completion when none remain
// - Basic continues only on fresh request
// - Completion pulse lasts exactly one clock
// - Auto-request: one request finishes cycle
// - Auto-request resumes without new request
// - Ping-pong alternates primary and alternate structures
// - Ping-pong batches continue on new request
// - Ping-pong task end pulses, awaits request
// - Invalid next structure ends ping-pong
// - Basic-typed ping-pong task ends the sequence
// - Exponent codes ten upward mean 1024
// - Full batches first, remainder last
// - High level first, then lower index
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
module dcs_sequencer (
	input  logic                    aclk,
	input  logic                    aresetn,
	input  logic [7:0]              awaddr,
	input  logic                    awvalid,
	output logic                    awready,
	input  logic [31:0]             wdata,
	input  logic [3:0]              wstrb,
	input  logic                    wvalid,
	output logic                    wready,
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  logic                    bready,
	input  logic [7:0]              araddr,
	input  logic                    arvalid,
	output logic                    arready,
	output logic [31:0]             rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  logic                    rready,
	input  logic [dcs_pkg::NCH-1:0] periph_req,
	output logic [dcs_pkg::NCH-1:0] cyc_done,
	output logic                    xfer_strobe,
	output logic [dcs_pkg::CH_W-1:0] xfer_chan
);
	import dcs_pkg::*;

	// Carriers to the bus front end and to the arbiter
	dcs_reg_if rif ();
	dcs_arb_if aif ();

	// Bus front end; a register write reaches this module as a one-cycle strobe
	dcs_axil_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.rif     (rif.bus)
	);

	// Purely combinational pick; the grant is registered here, in the idle state
	dcs_arbiter u_arb (
		.aif (aif.arb)
	);

	// Per-channel control, request and completion state
	logic [NCH-1:0]   en_r, en_nxt, hi_r, hi_nxt, alt_r, alt_nxt;
	logic [NCH-1:0]   pend_r, pend_nxt, auto_r, auto_nxt, done_r, done_nxt;
	logic [NCH-1:0]   sw_set, pclr;

	// Descriptor store: two structures per channel, alternate in the low index bit
	logic [DSC_W-1:0] desc_r [2*NCH];
	logic [DSC_W-1:0] desc_nxt [2*NCH];

	// Engine state and batch counters
	dcs_state_t       state_r, state_nxt;
	dcs_cyc_t         typ_r, typ_nxt, cur_typ;
	logic [CH_W-1:0]  ch_r, ch_nxt, xch_r, xch_nxt;
	logic [10:0]      cnt_r, cnt_nxt, rem_r, rem_nxt, rem_new, bsz;
	logic             xfer_r, xfer_nxt;

	// Decode helpers for the structure in use
	logic [2:0]       cur_idx, wr_idx;
	logic [DSC_W-1:0] cur_dsc;
	logic [31:0]      wv, stat;

	// Structure in use for the channel being served
	assign cur_idx = {ch_r, alt_r[ch_r]};
	assign cur_dsc = desc_r[cur_idx];
	assign cur_typ = dcs_cyc_t'(cur_dsc[DSC_TYP_LSB +: 3]);
	// Remaining count is the stored value plus one; eleven bits hold 1024
	assign rem_new = 11'({1'b0, cur_dsc[DSC_N_LSB +: 10]} + 11'h001);
	assign bsz     = batch_size(cur_dsc[DSC_RP_LSB +: 4]);
	assign wr_idx  = rif.wr_addr[4:2];

	// A channel bids when enabled and either requested or carrying an auto-request
	assign aif.cand = en_r & (pend_r | auto_r);
	assign aif.high = hi_r;

	// Register writes, then the sequencer; the sequencer's own write-back comes last
	// so it wins over a software write to the same field in the same cycle
	always_comb begin
		// Hold all state by default
		en_nxt    = en_r;
		hi_nxt    = hi_r;
		alt_nxt   = alt_r;
		auto_nxt  = auto_r;
		desc_nxt  = desc_r;
		state_nxt = state_r;
		typ_nxt   = typ_r;
		ch_nxt    = ch_r;
		cnt_nxt   = cnt_r;
		rem_nxt   = rem_r;
		xch_nxt   = xch_r;

		// One-cycle strobes and scratch values fall back to zero
		xfer_nxt  = 1'b0;
		done_nxt  = '0;
		sw_set    = '0;
		pclr      = '0;
		wv        = 32'h0;

		// Software writes, merged lane by lane into the current value
		if (rif.wr_en) begin
			if (rif.wr_addr == OFS_CTRL) begin
				wv     = wmerge({28'h0, en_r}, rif.wr_data, rif.wr_strb);
				en_nxt = wv[NCH-1:0];
			end else if (rif.wr_addr == OFS_PRIO) begin
				wv     = wmerge({28'h0, hi_r}, rif.wr_data, rif.wr_strb);
				hi_nxt = wv[NCH-1:0];
			end else if (rif.wr_addr == OFS_SWREQ) begin
				// Write-one-to-set; nothing is stored, so the word reads zero
				wv     = wmerge(32'h0, rif.wr_data, rif.wr_strb);
				sw_set = wv[NCH-1:0];
			end else if (rif.wr_addr == OFS_ALT) begin
				// Software may point a channel at either structure
				wv      = wmerge({28'h0, alt_r}, rif.wr_data, rif.wr_strb);
				alt_nxt = wv[NCH-1:0];
			end else if (rif.wr_addr >= OFS_DESC && rif.wr_addr <= OFS_DESC_END) begin
				// Word index picks channel and structure; top bits read zero
				wv               = wmerge({14'h0, desc_r[wr_idx]}, rif.wr_data, rif.wr_strb);
				desc_nxt[wr_idx] = wv[DSC_W-1:0];
			end
		end

		// Sequencer proper
		case (state_r)
			ST_ARB: begin
				// Whole pool is polled every time the engine is free
				if (aif.vld) begin
					// Grant consumes the request and any auto bid of the winner
					ch_nxt           = aif.ch;
					pclr[aif.ch]     = 1'b1;
					auto_nxt[aif.ch] = 1'b0;
					state_nxt        = ST_FETCH;
				end
			end

			// Decode the fetched type; an invalid or disabled structure is dropped
			ST_FETCH: begin
				typ_nxt = cur_typ;
				if (cur_typ == CYC_INVALID || !en_r[ch_r]) begin
					state_nxt = ST_ARB;
				end else begin
					// Whole remainder loaded; the batch is the smaller of the two
					rem_nxt   = rem_new;
					cnt_nxt   = (bsz < rem_new) ? bsz : rem_new;
					state_nxt = ST_XFER;
				end
			end

			ST_XFER: begin
				// Channel is locked until its batch count runs out
				xfer_nxt = 1'b1;
				xch_nxt  = ch_r;
				// Both counts step once per transfer
				cnt_nxt  = 11'(cnt_r - 11'h001);
				rem_nxt  = 11'(rem_r - 11'h001);
				if (cnt_r == 11'h001) begin
					state_nxt = ST_WB;
				end
			end

			// Write-back: close the cycle or record what is left
			ST_WB: begin
				if (rem_r == 11'h000) begin
					// Cycle over: kill the structure, pulse completion
					desc_nxt[cur_idx][DSC_TYP_LSB +: 3] = CYC_INVALID;
					done_nxt[ch_r] = 1'b1;
					// Ping-pong hands the next task to the other structure
					if (typ_r == CYC_PING) begin
						alt_nxt[ch_r] = ~alt_r[ch_r];
					end
					// A basic task does not flip, so the next fetch meets its invalid code
				end else begin
					desc_nxt[cur_idx][DSC_N_LSB +: 10] = 10'(rem_r - 11'h001);
					// Basic and ping-pong wait for a fresh request; auto kinds bid on
					if (typ_r == CYC_AUTO || typ_r == CYC_MSG_PRI || typ_r == CYC_MSG_ALT) begin
						auto_nxt[ch_r] = 1'b1;
					end
				end
				state_nxt = ST_ARB;
			end

			// Unused code recovers to idle
			default: begin
				state_nxt = ST_ARB;
			end
		endcase
		// A request in the grant cycle survives the clear
		pend_nxt = (pend_r & ~pclr) | periph_req | sw_set;
	end

	// Status word
	always_comb begin
		stat                   = 32'h0;
		stat[STAT_BUSY]        = (state_r != ST_ARB);
		stat[STAT_CH +: CH_W]  = ch_r;
		stat[STAT_PEND +: NCH] = pend_r;
		stat[STAT_AUTO +: NCH] = auto_r;
		stat[STAT_TYP +: 3]    = typ_r;
	end

	// Read decode; unmapped words answer zero
	always_comb begin
		if (rif.rd_addr == OFS_CTRL) begin
			rif.rd_data = {28'h0, en_r};
		end else if (rif.rd_addr == OFS_PRIO) begin
			rif.rd_data = {28'h0, hi_r};
		end else if (rif.rd_addr == OFS_ALT) begin
			rif.rd_data = {28'h0, alt_r};
		end else if (rif.rd_addr == OFS_STAT) begin
			rif.rd_data = stat;
		end else if (rif.rd_addr >= OFS_DESC && rif.rd_addr <= OFS_DESC_END) begin
			rif.rd_data = {14'h0, desc_r[rif.rd_addr[4:2]]};
		end else begin
			rif.rd_data = 32'h0;
		end
	end

	// All state on one synchronous, active-low reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_r    <= CH_RST;
			hi_r    <= CH_RST;
			alt_r   <= CH_RST;
			pend_r  <= CH_RST;
			auto_r  <= CH_RST;
			done_r  <= CH_RST;
			// Every structure starts invalid: no channel runs before set-up
			for (int i = 0; i < 2 * NCH; i++) begin
				desc_r[i] <= DSC_RST;
			end
			// Engine idle, waiting in arbitration
			state_r <= ST_ARB;
			typ_r   <= CYC_INVALID;
			ch_r    <= '0;
			xch_r   <= '0;
			cnt_r   <= 11'h000;
			rem_r   <= 11'h000;
			xfer_r  <= 1'b0;
		end else begin
			// Everything advances together on each edge
			en_r    <= en_nxt;
			hi_r    <= hi_nxt;
			alt_r   <= alt_nxt;
			pend_r  <= pend_nxt;
			auto_r  <= auto_nxt;
			done_r  <= done_nxt;
			desc_r  <= desc_nxt;
			// Engine state and counters
			state_r <= state_nxt;
			typ_r   <= typ_nxt;
			ch_r    <= ch_nxt;
			xch_r   <= xch_nxt;
			cnt_r   <= cnt_nxt;
			rem_r   <= rem_nxt;
			xfer_r  <= xfer_nxt;
		end
	end

	// Outputs straight from their flip-flops
	assign cyc_done    = done_r;
	assign xfer_strobe = xfer_r;
	assign xfer_chan   = xch_r;

endmodule // dcs_sequencer

/* File: test/dcs_seq_props.sv */
// Checker for the sequencer transfer and completion outputs
`timescale 1ns/10ps
module dcs_seq_props (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [3:0] cyc_done,
	input wire logic       xfer_strobe,
	input wire logic [1:0] xfer_chan
);
	logic [10:0] run_r;
	logic [10:0] run_nxt;

	// Length of the unbroken transfer run, cleared by any gap
	always_comb begin
		run_nxt = xfer_strobe ? run_r + 11'h001 : 11'h000;
	end
	always_ff @(posedge aclk) begin
		run_r <= aresetn ? run_nxt : 11'h000;
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_two_xfers;
		xfer_strobe ##1 xfer_strobe;
	endsequence
	sequence s_done;
		cyc_done != 4'h0;
	endsequence

	a_done_single: assert property (s_done |=> (cyc_done & $past(cyc_done)) == 4'h0)
		else $error("completion pulse longer than one clock");
	a_done_onehot: assert property ($onehot0(cyc_done))
		else $error("completion on several channels");
	a_done_chan: assert property (s_done |-> cyc_done == (4'h1 << xfer_chan))
		else $error("completion on a channel that did not transfer");
	a_done_after_xfer: assert property (s_done |-> $past(xfer_strobe) || $past(xfer_strobe, 2))
		else $error("completion without transfers");
	a_done_quiet: assert property (s_done |-> !xfer_strobe)
		else $error("transfer in the completion cycle");
	a_batch_chan: assert property (s_two_xfers |-> xfer_chan == $past(xfer_chan))
		else $error("channel changed inside a batch");
	a_batch_bound: assert property (run_r <= 11'h400)
		else $error("batch longer than 1024");
	a_batch_gap: assert property ($rose(xfer_strobe) |-> !$past(xfer_strobe, 2))
		else $error("no arbitration gap between batches");
endmodule // dcs_seq_props

/* File: test/dcs_periph_model.sv */
// Peripheral request sources facing the sequencer
`timescale 1ns/10ps
module dcs_periph_model (
	input wire logic       aclk,
	input wire logic [3:0] fire,
	input wire logic       slow,
	output logic [3:0]     periph_req
);
	logic [3:0] d1_r = 4'h0;
	logic [3:0] d2_r = 4'h0;
	logic [3:0] d3_r = 4'h0;

	// Slow sources answer two clocks later; pulses stay one clock wide
	always_ff @(posedge aclk) begin
		d1_r <= fire;
		d2_r <= d1_r;
		d3_r <= d2_r;
	end
	assign periph_req = slow ? d3_r : d1_r;
endmodule // dcs_periph_model

/* File: test/tb_dma_cycle_sequencer.sv */
// Self-checking bench for the cycle sequencer
`timescale 1ns/10ps
module tb_dma_cycle_sequencer;
	import dcs_pkg::*;
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata   = 32'h0;
	logic [3:0]  wstrb   = 4'hf;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic [7:0]  araddr  = 8'h00;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [3:0]  fire    = 4'h0;
	logic        slow    = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, xfer_strobe;
	logic [1:0]  bresp, rresp, xfer_chan, resp, f_ch;
	logic [31:0] rdata, rd;
	logic [3:0]  periph_req, cyc_done;
	int          num_errors  = 0;
	int          comparisons = 0;
	int          n_s, n_d, mx, n, r;
	int unsigned seed;

	always #25 aclk = ~aclk;

	dcs_sequencer DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .periph_req, .cyc_done, .xfer_strobe, .xfer_chan);
	dcs_periph_model PER (.aclk, .fire, .slow, .periph_req);

	function automatic logic [31:0] desc(input int c, input int n1, input int rp);
		return {14'h0, rp[3:0], n1[9:0], 1'b0, c[2:0]};
	endfunction
	function automatic int bsz(input int rp);
		return (rp >= 10) ? 1024 : (1 << rp);
	endfunction

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic tmo();
		num_errors++;
		$display("timeout at %0t", $time);
		results();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic expect_sd(input int s, input int d);
		chk(n_s, s);
		chk(n_d, d);
	endtask

	// Write and read, each held until its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (t = 0; t < 50; t++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		resp = bresp;
		if (t == 50) tmo();
	endtask
	task automatic rd_(input logic [7:0] a);
		int t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (t = 0; t < 50; t++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		rd = rdata;
		resp = rresp;
		if (t == 50) tmo();
	endtask

	// Pulse requests, then count until the outputs stay quiet
	task automatic go(input logic [3:0] m);
		int t;
		int q;
		int run;
		@(posedge aclk);
		fire <= m;
		n_s = 0;
		n_d = 0;
		mx = 0;
		run = 0;
		q = 0;
		for (t = 0; t < 5000 && q < 20; t++) begin
			@(posedge aclk);
			fire <= 4'h0;
			q = (xfer_strobe === 1'b1) ? 0 : q + 1;
			run = (xfer_strobe === 1'b1) ? run + 1 : 0;
			if (run == 1 && n_s == 0) f_ch = xfer_chan;
			if (run > 0) n_s++;
			if (run > mx) mx = run;
			if (cyc_done !== 4'h0) n_d++;
		end
		if (q < 20) tmo();
	endtask

	initial begin
		seed = $urandom(48892);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd_(OFS_CTRL);
		chk(rd, 32'h0);
		rd_(8'h14);
		chk(resp, RESP_SLVERR);
		wr(8'h40, 32'h1);
		chk(resp, RESP_SLVERR);
		wr(OFS_CTRL, 32'hf);
		chk(resp, RESP_OKAY);
		wstrb <= 4'he;
		wr(OFS_CTRL, 32'h0);
		wstrb <= 4'hf;
		rd_(OFS_CTRL);
		chk(rd, 32'hf);
		$display("test bus done");
		for (int c = 0; c < 8; c++) begin
			wr(OFS_ALT, 32'h0);
			wr(8'h28, desc(c, 0, 0));
			go(4'h2);
			expect_sd(c != 0, c != 0);
		end
		$display("test codes done");
		wr(8'h30, desc(1, 5, 2));
		go(4'h4);
		expect_sd(4, 0);
		rd_(8'h30);
		chk(rd, desc(1, 1, 2));
		go(4'h4);
		expect_sd(2, 1);
		rd_(8'h30);
		chk(rd[2:0], 3'h0);
		rd_(OFS_STAT);
		chk(rd, (32'h1 << STAT_TYP) | (32'h2 << STAT_CH));
		$display("test basic done");
		wr(OFS_ALT, 32'h0);
		wr(8'h20, desc(3, 1, 3));
		wr(8'h24, desc(3, 0, 0));
		go(4'h1);
		expect_sd(2, 1);
		rd_(OFS_ALT);
		chk(rd[0], 1'b1);
		wr(8'h20, desc(3, 0, 0));
		wr(OFS_SWREQ, 32'h1);
		go(4'h0);
		expect_sd(1, 1);
		go(4'h1);
		expect_sd(1, 1);
		go(4'h1);
		expect_sd(0, 0);
		wr(OFS_ALT, 32'h0);
		wr(8'h20, desc(3, 0, 0));
		wr(8'h24, desc(1, 0, 0));
		go(4'h1);
		go(4'h1);
		expect_sd(1, 1);
		go(4'h1);
		expect_sd(0, 0);
		$display("test pingpong done");
		wr(OFS_ALT, 32'h0);
		wr(OFS_PRIO, 32'h8);
		wr(8'h20, desc(2, 0, 0));
		wr(8'h38, desc(2, 0, 0));
		go(4'h9);
		chk(f_ch, 2'h3);
		expect_sd(2, 2);
		wr(OFS_PRIO, 32'h0);
		wr(8'h28, desc(2, 0, 0));
		wr(8'h38, desc(2, 0, 0));
		go(4'ha);
		chk(f_ch, 2'h1);
		$display("test priority done");
		slow <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			n = (k == 3) ? 1024 : 1 + $urandom % 40;
			r = (k == 3) ? 10 + $urandom % 6 : $urandom % 4;
			wr(8'h28, desc(2, n - 1, r));
			go(4'h2);
			expect_sd(n, 1);
			chk(mx, (n < bsz(r)) ? n : bsz(r));
		end
		$display("test auto done");
		results();
	end
endmodule // tb_dma_cycle_sequencer

bind dcs_sequencer dcs_seq_props PROPS (.aclk, .aresetn, .cyc_done, .xfer_strobe, .xfer_chan);
